/* File: dewu_pkg.sv */
// constants, register map and carrier types for the eeprom write-unlock host controller
package dewu_pkg;
    // device register selects on the device access port
    localparam logic [2:0] NV_ADDR_SEL = 3'h0;
    localparam logic [2:0] NV_DATA_SEL = 3'h1;
    localparam logic [2:0] NV_CTRL_SEL = 3'h2;
    localparam logic [2:0] NV_UNLOCK_SEL = 3'h3;
    localparam logic [2:0] IRQ_CTRL_SEL = 3'h4;
    localparam logic [2:0] FLAG_SEL = 3'h5;
    // device bit positions
    localparam int CTRL_RD_BIT = 0;
    localparam int CTRL_WR_BIT = 1;
    localparam int CTRL_WRITE_ENABLE_BIT_BIT = 2;
    localparam int CTRL_MSEL_BIT = 7;
    localparam int GIE_BIT = 7;
    localparam int DONE_FLAG_BIT = 4;
    // device values
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [8:0] NV_DEPTH = 9'h100;
    // controller registers on AHB-Lite (byte offsets)
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] ADDR_OFS = 8'h04;
    localparam logic [7:0] WDATA_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] RDATA_OFS = 8'h10;
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_WRITE_BIT = 1;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_ERR_BIT = 2;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam int HTRANS_ACT_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;
    // device access phases
    localparam logic [1:0] PH_IDLE = 2'h0;
    localparam logic [1:0] PH_STROBE = 2'h1;
    localparam logic [1:0] PH_WAIT = 2'h2;

    typedef struct packed {
        logic [2:0] sel;
        logic [7:0] wdata;
        logic we;
        logic re;
    } dewu_dev_s;

    typedef struct packed {
        logic valid;
        logic [7:0] ofs;
        logic [31:0] data;
    } dewu_regwr_s;

    typedef enum logic [4:0] {
        S_IDLE = 5'h00,
        S_POLL_WR = 5'h01,
        S_SET_ADDR = 5'h03,
        S_SET_DATA = 5'h02,
        S_SET_WRITE_ENABLE_BIT = 5'h06,
        S_GIE_RD = 5'h07,
        S_GIE_OFF = 5'h05,
        S_UNL1 = 5'h04,
        S_UNL2 = 5'h0C,
        S_SET_WR = 5'h0D,
        S_GIE_ON = 5'h0F,
        S_WRITE_ENABLE_BIT_OFF = 5'h0E,
        S_POLL_DONE = 5'h0A,
        S_CLR_FLAG = 5'h0B,
        S_FINISH = 5'h09,
        S_RD_ADDR = 5'h18,
        S_RD_CMD = 5'h19,
        S_RD_DATA = 5'h1B
    } dewu_state_e;
endpackage

/* File: dewu_dev_port.sv */
// one register access on the device port: strobe, then sample read data
`timescale 1ns/100ps
`default_nettype none
module dewu_dev_port (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // request from the sequencer
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [2:0] sel_i,
    input wire logic [7:0] wdata_i,
    output logic done_o,
    output logic [7:0] rdata_o,
    // device side
    output dewu_pkg::dewu_dev_s dev_o,
    input wire logic [7:0] dev_rdata_i
);
    import dewu_pkg::*;

    logic [1:0] ph_r, ph_nxt;
    dewu_dev_s bus_r, bus_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic done_r, done_nxt;

    always_comb begin
        ph_nxt = ph_r;
        bus_nxt = bus_r;
        rdata_nxt = rdata_r;
        done_nxt = 1'b0;
        case (ph_r)
            PH_IDLE: begin
                if (req_i) begin
                    bus_nxt = '{sel: sel_i, wdata: wdata_i, we: we_i, re: ~we_i};
                    ph_nxt = PH_STROBE;
                end
            end
            PH_STROBE: begin
                // strobes last exactly one cycle
                bus_nxt.we = 1'b0;
                bus_nxt.re = 1'b0;
                ph_nxt = PH_WAIT;
            end
            default: begin
                // byte stands on the device port the cycle after a read strobe
                rdata_nxt = dev_rdata_i;
                done_nxt = 1'b1;
                ph_nxt = PH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ph_r <= PH_IDLE;
            bus_r <= '0;
            rdata_r <= BYTE_ZERO;
            done_r <= 1'b0;
        end else begin
            ph_r <= ph_nxt;
            bus_r <= bus_nxt;
            rdata_r <= rdata_nxt;
            done_r <= done_nxt;
        end
    end

    assign dev_o = bus_r;
    assign done_o = done_r;
    assign rdata_o = rdata_r;
endmodule
`default_nettype wire

/* File: dewu_ahb_slave.sv */
// AHB-Lite slave front end: zero wait states, registered read data
`timescale 1ns/100ps
`default_nettype none
module dewu_ahb_slave (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // AHB-Lite
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // register core
    output logic [7:0] rd_ofs_o,
    input wire logic [31:0] rd_word_i,
    output dewu_pkg::dewu_regwr_s wr_o
);
    import dewu_pkg::*;

    logic wph_r, wph_nxt;
    logic [7:0] ofs_r, ofs_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic take;

    // only single word transfers are issued, so hsize is not decoded
    assign take = hsel_i & hready_i & htrans_i[HTRANS_ACT_BIT];
    assign rd_ofs_o = haddr_i[7:0];

    always_comb begin
        wph_nxt = take & hwrite_i;
        ofs_nxt = take ? haddr_i[7:0] : ofs_r;
        hrdata_nxt = hrdata_r;
        if (take && !hwrite_i) begin
            hrdata_nxt = rd_word_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wph_r <= 1'b0;
            ofs_r <= CMD_OFS;
            hrdata_r <= WORD_ZERO;
        end else begin
            wph_r <= wph_nxt;
            ofs_r <= ofs_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    assign wr_o = '{valid: wph_r, ofs: ofs_r, data: hwdata_i};
    assign hreadyout_o = 1'b1;
    assign hresp_o = HRESP_OKAY;
    assign hrdata_o = hrdata_r;
endmodule
`default_nettype wire

/* File: dewu_host.sv */
// host controller that reads and unlock-writes the data eeprom through its registers
// Notes on behaviour
// - write only after 55h, AAh, then write bit
// - unlock and write-bit set issued uninterrupted
// - done flag stays until software clears it
// - load address and data byte before unlocking
// - clear memory select to target data eeprom
// - address must lie inside eeprom size
// - test write bit before starting new write
// - global interrupts off during unlock sequence
// - write enable set only around the write
// - end of write seen by polling flag
// - read byte appears the next cycle
`timescale 1ns/100ps
`default_nettype none
module dewu_host (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // AHB-Lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    output logic [31:0] HRDATA_O,
    // device register port
    output dewu_pkg::dewu_dev_s DEV_O,
    input wire logic [7:0] DEV_RDATA_I,
    // status
    output logic BUSY_O
);
    import dewu_pkg::*;

    dewu_state_e state_r, state_nxt;
    logic write_op_r, write_op_nxt;
    logic [7:0] addr_r, addr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] irq_save_r, irq_save_nxt;
    logic done_r, done_nxt;
    logic err_r, err_nxt;
    logic pend_r, pend_nxt;

    logic [7:0] rd_ofs;
    logic [31:0] rd_word;
    dewu_regwr_s wr;
    logic acc_need, acc_we;
    logic [2:0] acc_sel;
    logic [7:0] acc_wdata;
    logic acc_req, acc_done;
    logic [7:0] acc_rdata;
    logic go, set_done, set_err;

    dewu_ahb_slave u_ahb (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .hsel_i(HSEL_I),
        .haddr_i(HADDR_I),
        .htrans_i(HTRANS_I),
        .hwrite_i(HWRITE_I),
        .hsize_i(HSIZE_I),
        .hwdata_i(HWDATA_I),
        .hready_i(HREADY_I),
        .hreadyout_o(HREADYOUT_O),
        .hresp_o(HRESP_O),
        .hrdata_o(HRDATA_O),
        .rd_ofs_o(rd_ofs),
        .rd_word_i(rd_word),
        .wr_o(wr)
    );

    dewu_dev_port u_dev (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .req_i(acc_req),
        .we_i(acc_we),
        .sel_i(acc_sel),
        .wdata_i(acc_wdata),
        .done_o(acc_done),
        .rdata_o(acc_rdata),
        .dev_o(DEV_O),
        .dev_rdata_i(DEV_RDATA_I)
    );

    // read side of the controller registers; unmapped offsets read zero
    always_comb begin
        rd_word = WORD_ZERO;
        if (rd_ofs == CMD_OFS) begin
            rd_word[CMD_WRITE_BIT] = write_op_r;
        end else if (rd_ofs == ADDR_OFS) begin
            rd_word[7:0] = addr_r;
        end else if (rd_ofs == WDATA_OFS) begin
            rd_word[7:0] = wdata_r;
        end else if (rd_ofs == STATUS_OFS) begin
            rd_word[ST_BUSY_BIT] = (state_r != S_IDLE);
            rd_word[ST_DONE_BIT] = done_r;
            rd_word[ST_ERR_BIT] = err_r;
        end else if (rd_ofs == RDATA_OFS) begin
            rd_word[7:0] = rdata_r;
        end
    end

    assign go = wr.valid && (wr.ofs == CMD_OFS) && wr.data[CMD_GO_BIT] && (state_r == S_IDLE);

    // device access wanted by each state
    always_comb begin
        acc_need = 1'b1;
        acc_we = 1'b1;
        acc_sel = NV_CTRL_SEL;
        acc_wdata = BYTE_ZERO;
        case (state_r)
            S_POLL_WR: begin
                acc_we = 1'b0;
            end
            S_SET_ADDR, S_RD_ADDR: begin
                acc_sel = NV_ADDR_SEL;
                acc_wdata = addr_r;
            end
            S_SET_DATA: begin
                acc_sel = NV_DATA_SEL;
                acc_wdata = wdata_r;
            end
            S_SET_WRITE_ENABLE_BIT: begin
                // memory select left clear, write enable raised
                acc_wdata[CTRL_WRITE_ENABLE_BIT_BIT] = 1'b1;
            end
            S_GIE_RD: begin
                acc_we = 1'b0;
                acc_sel = IRQ_CTRL_SEL;
            end
            S_GIE_OFF: begin
                acc_sel = IRQ_CTRL_SEL;
                acc_wdata = irq_save_r;
                acc_wdata[GIE_BIT] = 1'b0;
            end
            S_UNL1: begin
                acc_sel = NV_UNLOCK_SEL;
                acc_wdata = UNLOCK_KEY1;
            end
            S_UNL2: begin
                acc_sel = NV_UNLOCK_SEL;
                acc_wdata = UNLOCK_KEY2;
            end
            S_SET_WR: begin
                acc_wdata[CTRL_WRITE_ENABLE_BIT_BIT] = 1'b1;
                acc_wdata[CTRL_WR_BIT] = 1'b1;
            end
            S_GIE_ON: begin
                acc_sel = IRQ_CTRL_SEL;
                acc_wdata = irq_save_r;
            end
            S_WRITE_ENABLE_BIT_OFF: begin
                // safe mid-cycle: dropping write enable does not abort it
                acc_wdata = BYTE_ZERO;
            end
            S_POLL_DONE: begin
                acc_we = 1'b0;
                acc_sel = FLAG_SEL;
            end
            S_CLR_FLAG: begin
                acc_sel = FLAG_SEL;
                acc_wdata = BYTE_ZERO;
            end
            S_RD_CMD: begin
                acc_wdata[CTRL_RD_BIT] = 1'b1;
            end
            S_RD_DATA: begin
                acc_we = 1'b0;
                acc_sel = NV_DATA_SEL;
            end
            default: begin
                acc_need = 1'b0;
            end
        endcase
    end

    // one access outstanding at a time, so nothing interleaves the unlock
    assign acc_req = acc_need & ~pend_r;

    // sequencer
    always_comb begin
        state_nxt = state_r;
        write_op_nxt = write_op_r;
        irq_save_nxt = irq_save_r;
        rdata_nxt = rdata_r;
        pend_nxt = pend_r;
        set_done = 1'b0;
        set_err = 1'b0;
        if (acc_req) begin
            pend_nxt = 1'b1;
        end else if (acc_done) begin
            pend_nxt = 1'b0;
        end
        case (state_r)
            S_IDLE: begin
                if (go) begin
                    write_op_nxt = wr.data[CMD_WRITE_BIT];
                    if ({1'b0, addr_r} >= NV_DEPTH) begin
                        set_err = 1'b1;
                    end else if (wr.data[CMD_WRITE_BIT]) begin
                        state_nxt = S_POLL_WR;
                    end else begin
                        state_nxt = S_RD_ADDR;
                    end
                end
            end
            S_POLL_WR: begin
                // device holds the write bit for its whole cycle
                if (acc_done && !acc_rdata[CTRL_WR_BIT]) begin
                    state_nxt = S_SET_ADDR;
                end
            end
            S_SET_ADDR: begin
                if (acc_done) begin
                    state_nxt = S_SET_DATA;
                end
            end
            S_SET_DATA: begin
                if (acc_done) begin
                    state_nxt = S_SET_WRITE_ENABLE_BIT;
                end
            end
            S_SET_WRITE_ENABLE_BIT: begin
                if (acc_done) begin
                    state_nxt = S_GIE_RD;
                end
            end
            S_GIE_RD: begin
                if (acc_done) begin
                    irq_save_nxt = acc_rdata;
                    state_nxt = S_GIE_OFF;
                end
            end
            S_GIE_OFF: begin
                if (acc_done) begin
                    state_nxt = S_UNL1;
                end
            end
            S_UNL1: begin
                if (acc_done) begin
                    state_nxt = S_UNL2;
                end
            end
            S_UNL2: begin
                if (acc_done) begin
                    state_nxt = S_SET_WR;
                end
            end
            S_SET_WR: begin
                if (acc_done) begin
                    state_nxt = S_GIE_ON;
                end
            end
            S_GIE_ON: begin
                if (acc_done) begin
                    state_nxt = S_WRITE_ENABLE_BIT_OFF;
                end
            end
            S_WRITE_ENABLE_BIT_OFF: begin
                // device never drops write enable, so the host does it
                if (acc_done) begin
                    state_nxt = S_POLL_DONE;
                end
            end
            S_POLL_DONE: begin
                // no fixed wait: poll until the device raises its done flag
                if (acc_done && acc_rdata[DONE_FLAG_BIT]) begin
                    state_nxt = S_CLR_FLAG;
                end
            end
            S_CLR_FLAG: begin
                if (acc_done) begin
                    state_nxt = S_FINISH;
                end
            end
            S_RD_ADDR: begin
                if (acc_done) begin
                    state_nxt = S_RD_CMD;
                end
            end
            S_RD_CMD: begin
                if (acc_done) begin
                    state_nxt = S_RD_DATA;
                end
            end
            S_RD_DATA: begin
                if (acc_done) begin
                    rdata_nxt = acc_rdata;
                    state_nxt = S_FINISH;
                end
            end
            default: begin
                set_done = 1'b1;
                state_nxt = S_IDLE;
            end
        endcase
    end

    // software registers; a hardware set wins over a clear in the same cycle
    always_comb begin
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        done_nxt = done_r;
        err_nxt = err_r;
        if (wr.valid && (state_r == S_IDLE)) begin
            if (wr.ofs == ADDR_OFS) begin
                addr_nxt = wr.data[7:0];
            end else if (wr.ofs == WDATA_OFS) begin
                wdata_nxt = wr.data[7:0];
            end
        end
        if (wr.valid && (wr.ofs == STATUS_OFS)) begin
            if (wr.data[ST_DONE_BIT]) begin
                done_nxt = 1'b0;
            end
            if (wr.data[ST_ERR_BIT]) begin
                err_nxt = 1'b0;
            end
        end
        if (set_done) begin
            done_nxt = 1'b1;
        end
        if (set_err) begin
            err_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_r <= S_IDLE;
            write_op_r <= 1'b0;
            addr_r <= BYTE_ZERO;
            wdata_r <= BYTE_ZERO;
            rdata_r <= BYTE_ZERO;
            irq_save_r <= BYTE_ZERO;
            done_r <= 1'b0;
            err_r <= 1'b0;
            pend_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            write_op_r <= write_op_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            irq_save_r <= irq_save_nxt;
            done_r <= done_nxt;
            err_r <= err_nxt;
            pend_r <= pend_nxt;
        end
    end

    assign BUSY_O = (state_r != S_IDLE);
endmodule
`default_nettype wire

/* File: dewu_host_assertions.sv */
// assertions on the device access sequence of the eeprom host
`timescale 1ns/100ps
`default_nettype none
module dewu_host_assertions
    import dewu_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // watched outputs
    input wire dewu_pkg::dewu_dev_s DEV_O,
    input wire logic BUSY_O
);
    logic s, w, c, k1, k1_r, k2_r, rd_r, dt_r, goff_r, wen_r;
    assign s = DEV_O.we | DEV_O.re;
    assign w = DEV_O.we;
    assign c = w && DEV_O.sel == NV_CTRL_SEL;
    assign k1 = w && DEV_O.sel == NV_UNLOCK_SEL && DEV_O.wdata == UNLOCK_KEY1;
    // remembers the previous access, so order checks stay one step long
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            {k1_r, k2_r, rd_r, dt_r, goff_r, wen_r} <= 6'h00;
        end else if (s) begin
            k1_r <= k1;
            k2_r <= w && DEV_O.sel == NV_UNLOCK_SEL && DEV_O.wdata == UNLOCK_KEY2;
            rd_r <= c && DEV_O.wdata[CTRL_RD_BIT];
            if (w && DEV_O.sel == NV_DATA_SEL)
                dt_r <= 1'b1;
            else if (c && DEV_O.wdata[CTRL_WR_BIT])
                dt_r <= 1'b0;
            if (w && DEV_O.sel == IRQ_CTRL_SEL)
                goff_r <= !DEV_O.wdata[GIE_BIT];
            if (c)
                wen_r <= DEV_O.wdata[CTRL_WRITE_ENABLE_BIT_BIT];
        end
    end
    default clocking dc @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    AST_KEY_ORDER: assert property (s && k1_r |-> w && DEV_O.sel == NV_UNLOCK_SEL
        && DEV_O.wdata == UNLOCK_KEY2) else $error("second key not next");
    AST_WR_AFTER_KEYS: assert property (s && k2_r |-> c && DEV_O.wdata[CTRL_WR_BIT]
        && DEV_O.wdata[CTRL_WRITE_ENABLE_BIT_BIT]) else $error("write bit not after keys");
    AST_WR_ONLY_KEYED: assert property (c && DEV_O.wdata[CTRL_WR_BIT] |-> k2_r)
        else $error("write bit without keys");
    AST_MSEL_CLEAR: assert property (c |-> !DEV_O.wdata[CTRL_MSEL_BIT])
        else $error("memory select set");
    AST_LOAD_FIRST: assert property (k1 |-> dt_r)
        else $error("unlock before data load");
    AST_IRQ_OFF: assert property (k1 |-> goff_r)
        else $error("unlock with interrupts on");
    AST_WRITE_ENABLE_BIT_IDLE: assert property (!BUSY_O |-> !wen_r)
        else $error("write enable left set");
    AST_FLAG_CLEAR: assert property (w && DEV_O.sel == FLAG_SEL
        |-> DEV_O.wdata == BYTE_ZERO ##[1:12] !BUSY_O) else $error("flag clear wrong");
    AST_READ_NEXT: assert property (s && rd_r |-> DEV_O.re && DEV_O.sel == NV_DATA_SEL)
        else $error("data read not next");
    AST_GAP: assert property (s |=> !s [*2])
        else $error("accesses too close");
    cover property (k1);
    cover property (s && rd_r);
    cover property (w && DEV_O.sel == FLAG_SEL);
endmodule
`default_nettype wire

/* File: dewu_nv_model.sv */
// data eeprom model: registers, unlock tracker and timed byte write
`timescale 1ns/100ps
`default_nettype none
module dewu_nv_model
    import dewu_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // register port and write time in cycles
    input wire dewu_pkg::dewu_dev_s dev_i,
    input wire logic [15:0] wr_len_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_r [0:255];
    logic [7:0] addr_r, data_r, irq_r, flag_r, rv;
    logic [15:0] cnt_r;
    logic [1:0] unl_r;
    logic write_enable_bit_r, wr_r;
    int wr_cnt_r;
    always_comb begin
        case (dev_i.sel)
            NV_ADDR_SEL: rv = addr_r;
            NV_DATA_SEL: rv = data_r;
            NV_CTRL_SEL: rv = {5'h00, write_enable_bit_r, wr_r, 1'b0};
            IRQ_CTRL_SEL: rv = irq_r;
            FLAG_SEL: rv = flag_r;
            default: rv = BYTE_ZERO;
        endcase
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {addr_r, data_r, flag_r, rdata_o} <= 32'h0000_0000;
            irq_r <= 8'h80;
            {cnt_r, unl_r, write_enable_bit_r, wr_r} <= 20'h00000;
            wr_cnt_r <= 0;
        end else begin
            // an unread cycle never repeats the last byte
            rdata_o <= dev_i.re ? rv : ~rdata_o;
            if (dev_i.we | dev_i.re)
                unl_r <= 2'h0;
            if (wr_r) begin
                cnt_r <= cnt_r + 16'h0001;
                if (cnt_r == wr_len_i) begin
                    wr_r <= 1'b0;
                    flag_r[DONE_FLAG_BIT] <= 1'b1;
                    mem_r[addr_r] <= data_r;
                    wr_cnt_r <= wr_cnt_r + 1;
                end
            end
            if (dev_i.we) begin
                case (dev_i.sel)
                    NV_ADDR_SEL: addr_r <= dev_i.wdata;
                    NV_DATA_SEL: data_r <= dev_i.wdata;
                    NV_UNLOCK_SEL: unl_r <= (dev_i.wdata == UNLOCK_KEY1) ? 2'h1 :
                        (unl_r == 2'h1 && dev_i.wdata == UNLOCK_KEY2) ? 2'h2 : 2'h0;
                    NV_CTRL_SEL: begin
                        write_enable_bit_r <= dev_i.wdata[CTRL_WRITE_ENABLE_BIT_BIT];
                        if (dev_i.wdata[CTRL_WR_BIT] && write_enable_bit_r && unl_r == 2'h2 && !wr_r) begin
                            wr_r <= 1'b1;
                            cnt_r <= 16'h0000;
                        end
                        if (dev_i.wdata[CTRL_RD_BIT] && !dev_i.wdata[CTRL_MSEL_BIT])
                            data_r <= mem_r[addr_r];
                    end
                    IRQ_CTRL_SEL: irq_r <= dev_i.wdata;
                    FLAG_SEL: flag_r <= dev_i.wdata;
                    default: ;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the eeprom write-unlock host controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import dewu_pkg::*;
    typedef struct packed {logic on; logic [31:0] v;} dewu_exp_s;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_dph = 1'b0;
    logic [31:0] haddr = WORD_ZERO, hwdata = WORD_ZERO, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hresp, busy;
    logic [7:0] dev_rdata, rnd = 8'h32;
    logic [15:0] wr_len = 16'h0003;
    dewu_dev_s dev;
    dewu_exp_s exp_q[$];
    int failures = 0, checks = 0, cyc = 0;
    always #5 clk = ~clk;
    dewu_host dewu_host_inst (.CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata),
        .DEV_O(dev), .DEV_RDATA_I(dev_rdata), .BUSY_O(busy));
    dewu_nv_model dewu_nv_model_inst (.clk_i(clk), .rst_n_i(rst_n), .dev_i(dev),
        .wr_len_i(wr_len), .rdata_o(dev_rdata));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] ofs, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, ofs};
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] ofs, input logic [31:0] e);
        exp_q.push_back({1'b1, e});
        ahb(1'b0, ofs, WORD_ZERO);
    endtask
    task automatic start(input logic w, input logic [7:0] a, input logic [7:0] d);
        ahb(1'b1, ADDR_OFS, {24'h000000, a});
        ahb(1'b1, WDATA_OFS, {24'h000000, d});
        ahb(1'b1, CMD_OFS, {30'h00000000, w, 1'b1});
    endtask
    // busy is sampled on the falling edge to stay clear of the launch edge
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (busy !== lvl && n < 20000);
        if (n >= 20000)
            chk("busy level", {31'h0, lvl}, {31'h0, busy});
        @(posedge clk);
    endtask
    task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
        start(w, a, d);
        wait_busy(1'b1);
        wait_busy(1'b0);
    endtask
    always @(posedge clk) begin
        if (rd_dph && hready === 1'b1 && exp_q.size() > 0) begin
            if (exp_q[0].on)
                chk("hrdata", exp_q[0].v, hrdata);
            chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
            void'(exp_q.pop_front());
        end
        rd_dph <= hsel && hready && htrans[HTRANS_ACT_BIT] && !hwrite;
        cyc++;
        if (cyc == 40000) begin
            failures++;
            summarize;
        end
    end
    initial begin
        logic [7:0] a, d, prev;
        int n0;
        prev = BYTE_ZERO;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(STATUS_OFS, WORD_ZERO);
        rd(CMD_OFS, WORD_ZERO);
        rd(RDATA_OFS, WORD_ZERO);
        ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
        rd(8'h20, WORD_ZERO);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            a = rnd;
            rnd = lfsr(rnd);
            d = rnd;
            wr_len <= i[0] ? 16'h00C8 : 16'h0003;
            op(1'b1, a, d);
            chk("eeprom byte", {24'h0, d}, {24'h0, dewu_nv_model_inst.mem_r[a]});
            chk("gie", 32'h80, {24'h0, dewu_nv_model_inst.irq_r});
            chk("flag", WORD_ZERO, {24'h0, dewu_nv_model_inst.flag_r});
            rd(STATUS_OFS, 32'h2);
            rd(STATUS_OFS, 32'h2);
            rd(CMD_OFS, 32'h2);
            rd(RDATA_OFS, {24'h0, prev});
            ahb(1'b1, STATUS_OFS, 32'h2);
            rd(STATUS_OFS, WORD_ZERO);
            op(1'b0, a, BYTE_ZERO);
            rd(RDATA_OFS, {24'h0, d});
            prev = d;
        end
        wr_len <= 16'h0190;
        n0 = dewu_nv_model_inst.wr_cnt_r;
        start(1'b1, 8'h5A, 8'hC3);
        wait_busy(1'b1);
        rd(STATUS_OFS, 32'h3);
        ahb(1'b1, ADDR_OFS, 32'hA5);
        ahb(1'b1, CMD_OFS, 32'h3);
        wait_busy(1'b0);
        chk("write count", n0 + 1, dewu_nv_model_inst.wr_cnt_r);
        chk("eeprom byte", 32'hC3, {24'h0, dewu_nv_model_inst.mem_r[8'h5A]});
        start(1'b1, 8'h11, 8'h22);
        wait_busy(1'b1);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(STATUS_OFS, WORD_ZERO);
        rd(RDATA_OFS, WORD_ZERO);
        op(1'b1, 8'h00, 8'hFF);
        chk("eeprom byte", 32'hFF, {24'h0, dewu_nv_model_inst.mem_r[8'h00]});
        @(posedge clk);
        summarize;
    end
endmodule
bind dewu_host dewu_host_assertions dewu_host_assertions_inst (.CLK_I(CLK_I),
    .RST_N_I(RST_N_I), .DEV_O(DEV_O), .BUSY_O(BUSY_O));
`default_nettype wire
